/* verilog/psic_power_irq_ctrl.sv */
// operating states, interrupt latching and pin drive of the sensor core
`timescale 1ns/10ps
module psic_power_irq_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic bus_clk,
  input wire logic bus_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_stop,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  output logic bus_busy,
  input wire logic [psic_pkg::MOTION_SRC_N-1:0] motion_evt,
  input wire logic [psic_pkg::MOTION_SRC_N-1:0] motion_raw,
  input wire logic [psic_pkg::FIFO_SRC_N-1:0] fifo_evt,
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe,
  output logic irq_pin_two_out,
  output logic irq_pin_two_oe,
  output logic data_update
);
  import psic_pkg::*;

  localparam int WAKE_BOUND = 200;

  psic_core_t st;
  psic_core_t next_st;
  psic_req_t link_req;
  logic link_req_tgl;
  logic link_stop_tgl;
  logic cmd_act;
  logic cmd_go;
  logic do_wr;
  logic do_rd;
  logic wr_ok;
  logic clr_write;
  logic in_wake;
  logic samp_tick;
  logic stop_evt;
  logic acq_hit;
  logic ev_any;
  logic soft_reset;
  logic [MOTION_SRC_N-1:0] motion_gate;
  logic [MOTION_SRC_N-1:0] motion_hit;
  logic [MOTION_SRC_N-1:0] raw_view;
  logic [FIFO_SRC_N-1:0] fifo_hit;

  // ==========================================
  // link domain front end
  psic_link_front u_link (
    .bus_clk(bus_clk),
    .bus_rst(bus_rst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_stop(bus_stop),
    .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid),
    .bus_busy(bus_busy),
    .link_req(link_req),
    .link_req_tgl(link_req_tgl),
    .link_stop_tgl(link_stop_tgl),
    .core_ack_tgl(st.ack_tgl),
    .core_rdata(st.rdata)
  );

  // ==========================================
  // pin drive from request level
  function automatic psic_pin_t pin_drive(input logic req, input logic pp, input logic ah);
    psic_pin_t p;
    logic lvl;
    lvl = ah ? req : ~req;
    p.out = pp ? lvl : 1'b0;
    p.oe = pp ? 1'b1 : ~lvl;
    return p;
  endfunction

  // ==========================================
  // request decode and event gating
  assign cmd_act = st.req_sync[2] != st.req_sync[1];
  assign cmd_go = cmd_act && clk_en;
  assign stop_evt = st.stop_sync[2] != st.stop_sync[1];
  assign do_wr = cmd_act && link_req.wr;
  assign do_rd = cmd_act && link_req.rd;
  assign in_wake = st.phase == PH_WAKE;
  // wake locks every stored register except the mode, reset and interrupt status registers
  assign wr_ok = do_wr && (!in_wake || link_req.addr == REG_MODE
                 || link_req.addr == REG_RESET || link_req.addr == REG_INT_STATUS);
  assign clr_write = wr_ok && link_req.addr == REG_INT_STATUS;
  assign soft_reset = wr_ok && link_req.addr == REG_RESET && link_req.wdata == RESET_CMD
                      && st.phase != PH_SLEEP;
  assign samp_tick = in_wake && st.samp_cnt == ZERO8;
  assign motion_gate[BIT_TILT] = st.feat[FEAT_TILTFLIP] & st.int_en[BIT_TILT];
  assign motion_gate[BIT_FLIP] = st.feat[FEAT_TILTFLIP] & st.int_en[BIT_FLIP];
  assign motion_gate[BIT_ANY_MOTION] = st.feat[FEAT_ANY_MOTION] & st.int_en[BIT_ANY_MOTION];
  assign motion_gate[BIT_SHAKE] = st.feat[FEAT_ANY_MOTION] & st.feat[FEAT_SHAKE]
                                  & st.int_en[BIT_SHAKE];
  assign motion_gate[BIT_TILT35] = st.feat[FEAT_ANY_MOTION] & st.feat[FEAT_TILT35]
                                   & st.int_en[BIT_TILT35];
  assign motion_hit = motion_evt & motion_gate & {MOTION_SRC_N{in_wake}};
  assign fifo_hit = fifo_evt & st.fifo_ctl[FIFO_SRC_N-1:0]
                    & {FIFO_SRC_N{st.fifo_ctl[FIFO_EN_BIT]}};
  assign acq_hit = samp_tick & st.int_en[BIT_ACQ];
  assign ev_any = (|motion_hit) | (|fifo_hit) | acq_hit;
  assign raw_view = motion_raw & {st.feat[FEAT_TILT35], st.feat[FEAT_SHAKE],
                    st.feat[FEAT_ANY_MOTION], st.feat[FEAT_TILTFLIP], st.feat[FEAT_TILTFLIP]};

  // ==========================================
  // next state
  always_comb begin
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] rd_val;
    logic fifo_clr;
    logic req_sm;
    logic req_fifo;
    logic req1;
    logic req2;
    set_vec = ZERO8;
    clr_vec = ZERO8;
    rd_val = ZERO8;
    fifo_clr = 1'b0;
    req_sm = 1'b0;
    req_fifo = 1'b0;
    req1 = 1'b0;
    req2 = 1'b0;
    next_st = st;
    next_st.req_sync = {st.req_sync[1:0], link_req_tgl};
    next_st.stop_sync = {st.stop_sync[1:0], link_stop_tgl};
    next_st.data_update = 1'b0;
    // sample timing runs only in wake; sleep and standby hold it
    if (samp_tick) begin
      next_st.samp_cnt = SAMPLE_CYC - CNT_ONE;
      next_st.data_update = st.stop_seen;
      next_st.stop_seen = stop_evt;
    end else if (in_wake) begin
      next_st.samp_cnt = st.samp_cnt - CNT_ONE;
      next_st.stop_seen = st.stop_seen | stop_evt;
    end else begin
      next_st.stop_seen = st.stop_seen | stop_evt;
    end
    // standby to wake settles in one sample period
    if (st.waking) begin
      if (st.wake_cnt == ZERO8) begin
        next_st.phase = PH_WAKE;
        next_st.waking = 1'b0;
        next_st.samp_cnt = SAMPLE_CYC - CNT_ONE;
      end else begin
        next_st.wake_cnt = st.wake_cnt - CNT_ONE;
      end
    end
    // register read mux
    unique case (link_req.addr)
      REG_MOTION_FLAGS, REG_MOTION_MIRROR: rd_val[MOTION_SRC_N-1:0] = raw_view;
      REG_DEV_STATUS: begin
        rd_val[1:0] = st.phase;
        rd_val[STAT_SAMPLE_FLAG] = st.samp_flag;
      end
      REG_INT_ENABLE: rd_val = st.int_en;
      REG_MODE: rd_val[1:0] = st.mode_sel;
      REG_FEATURE: rd_val = st.feat;
      REG_INT_STATUS: begin
        rd_val = st.int_status;
        rd_val[BIT_FIFO] = |st.fifo_status;
      end
      REG_FIFO_CTL: rd_val = st.fifo_ctl;
      REG_FIFO_STATUS: rd_val[FIFO_SRC_N-1:0] = st.fifo_status;
      REG_ROUTING: rd_val = st.route;
      REG_PIN_DRIVE: rd_val = st.drive;
      default: rd_val = ZERO8;
    endcase
    if (cmd_act) begin
      next_st.ack_tgl = ~st.ack_tgl;
      if (do_rd) begin
        next_st.rdata = rd_val;
      end
    end
    // sample flag: set wins over the clear on read
    if (do_rd && link_req.addr == REG_DEV_STATUS) begin
      next_st.samp_flag = 1'b0;
    end
    if (samp_tick) begin
      next_st.samp_flag = 1'b1;
    end
    // register writes
    if (wr_ok) begin
      unique case (link_req.addr)
        REG_INT_ENABLE: next_st.int_en = link_req.wdata;
        REG_FEATURE: next_st.feat = link_req.wdata;
        REG_FIFO_CTL: next_st.fifo_ctl = link_req.wdata;
        REG_ROUTING: next_st.route = link_req.wdata;
        REG_PIN_DRIVE: next_st.drive = link_req.wdata;
        REG_MODE: begin
          unique case (link_req.wdata[1:0])
            PH_SLEEP: begin
              next_st.phase = PH_SLEEP;
              next_st.waking = 1'b0;
              next_st.mode_sel = link_req.wdata[1:0];
            end
            PH_STANDBY: begin
              next_st.phase = PH_STANDBY;
              next_st.waking = 1'b0;
              next_st.mode_sel = link_req.wdata[1:0];
            end
            PH_WAKE: begin
              next_st.mode_sel = link_req.wdata[1:0];
              if (!in_wake && !st.waking) begin
                next_st.waking = 1'b1;
                next_st.wake_cnt = WAKE_CYC - CNT_ONE;
              end
            end
            default: next_st.mode_sel = st.mode_sel;
          endcase
        end
        default: next_st.mode_sel = next_st.mode_sel;
      endcase
    end
    // clearing: global ignores the data, per-bit clears the ones
    if (clr_write) begin
      clr_vec = st.route[ROUTE_PER_BIT] ? link_req.wdata : ONES8;
      fifo_clr = clr_vec[BIT_FIFO];
    end
    set_vec[MOTION_SRC_N-1:0] = motion_hit;
    set_vec[BIT_ACQ] = acq_hit;
    next_st.int_status = (st.int_status & ~clr_vec) | set_vec;
    next_st.fifo_status = (st.fifo_status & ~{FIFO_SRC_N{fifo_clr}}) | fifo_hit;
    // full soft reset keeps only the crossing handshake alive
    if (soft_reset) begin
      next_st = '0;
      next_st.req_sync = {st.req_sync[1:0], link_req_tgl};
      next_st.stop_sync = {st.stop_sync[1:0], link_stop_tgl};
      next_st.ack_tgl = ~st.ack_tgl;
      next_st.rdata = st.rdata;
    end
    // pin routing and drive
    req_sm = |next_st.int_status;
    req_fifo = |next_st.fifo_status;
    if (next_st.route[ROUTE_MERGE]) begin
      req1 = (req_sm | req_fifo) & ~next_st.route[ROUTE_MERGE_PIN];
      req2 = (req_sm | req_fifo) & next_st.route[ROUTE_MERGE_PIN];
    end else if (next_st.route[ROUTE_SWAP]) begin
      req1 = req_fifo;
      req2 = req_sm;
    end else begin
      req1 = req_sm;
      req2 = req_fifo;
    end
    next_st.pin1 = pin_drive(req1, next_st.drive[DRV_PIN1_PP],
                             next_st.drive[DRV_PIN1_AH]);
    next_st.pin2 = pin_drive(req2, next_st.drive[DRV_PIN2_PP],
                             next_st.drive[DRV_PIN2_AH]);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign irq_pin_one_out = st.pin1.out;
  assign irq_pin_one_oe = st.pin1.oe;
  assign irq_pin_two_out = st.pin2.out;
  assign irq_pin_two_oe = st.pin2.oe;
  assign data_update = st.data_update;

  // ==========================================
  // checks
  property p_boot_sleep;
    @(posedge ref_clk) disable iff (sys_rst)
      $past(sys_rst) |-> st.phase == PH_SLEEP;
  endproperty
  a_boot_sleep: assert property (p_boot_sleep) else $error("not asleep after reset");

  property p_no_auto;
    @(posedge ref_clk) disable iff (sys_rst)
      $changed(st.phase) |-> $past(cmd_go) || $past(st.waking);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("state changed by itself");

  property p_wake_time;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(st.waking) |-> ##[1:WAKE_BOUND] !st.waking;
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("wake took too long");

  property p_reset_refused;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && do_wr && link_req.addr == REG_RESET && link_req.wdata == RESET_CMD
      && st.phase == PH_SLEEP |=> $stable(st.int_en) && $stable(st.route);
  endproperty
  a_reset_refused: assert property (p_reset_refused) else $error("reset taken asleep");

  property p_reset_taken;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && soft_reset |=> st.int_en == ZERO8 && st.phase == PH_SLEEP && !st.waking;
  endproperty
  a_reset_taken: assert property (p_reset_taken) else $error("soft reset incomplete");

  property p_wake_lock;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && do_wr && in_wake && link_req.addr == REG_INT_ENABLE |=> $stable(st.int_en);
  endproperty
  a_wake_lock: assert property (p_wake_lock) else $error("write took effect in wake");

  property p_status_read;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && do_rd && link_req.addr == REG_DEV_STATUS |=> st.rdata[1:0] == $past(st.phase);
  endproperty
  a_status_read: assert property (p_status_read) else $error("state readback wrong");

  property p_global_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && clr_write && !st.route[ROUTE_PER_BIT] && !ev_any
      |=> st.int_status == ZERO8 && st.fifo_status == '0;
  endproperty
  a_global_clear: assert property (p_global_clear) else $error("global clear failed");

  property p_gate;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(st.int_status[BIT_ANY_MOTION]) |-> $past(st.int_en[BIT_ANY_MOTION]) && $past(st.feat[FEAT_ANY_MOTION]);
  endproperty
  a_gate: assert property (p_gate) else $error("ungated motion status");

  property p_sample_flag;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && samp_tick |=> st.samp_flag ##1 !samp_tick;
  endproperty
  a_sample_flag: assert property (p_sample_flag) else $error("sample flag missed");

  property p_pin_release;
    @(posedge ref_clk) disable iff (sys_rst)
      clk_en && clr_write && !st.route[ROUTE_PER_BIT] && !ev_any && st.drive == ZERO8
      |=> !st.pin1.oe && !st.pin2.oe;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin held after clear");

  c_wake: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(st.waking) && in_wake);
  c_pin1: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(st.pin1.oe));
  c_soft: cover property (@(posedge ref_clk) disable iff (sys_rst) clk_en && soft_reset);
  c_perbit: cover property (@(posedge ref_clk) disable iff (sys_rst)
                            clk_en && clr_write && st.route[ROUTE_PER_BIT]);
endmodule

/* include/psic_pkg.sv */
// constants and carrier types of the power state and interrupt controller
package psic_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] REG_MOTION_FLAGS = 8'h03;
  localparam logic [7:0] REG_DEV_STATUS = 8'h05;
  localparam logic [7:0] REG_INT_ENABLE = 8'h06;
  localparam logic [7:0] REG_MODE = 8'h07;
  localparam logic [7:0] REG_FEATURE = 8'h09;
  localparam logic [7:0] REG_MOTION_MIRROR = 8'h13;
  localparam logic [7:0] REG_INT_STATUS = 8'h14;
  localparam logic [7:0] REG_RESET = 8'h1c;
  localparam logic [7:0] REG_FIFO_CTL = 8'h2d;
  localparam logic [7:0] REG_FIFO_STATUS = 8'h2f;
  localparam logic [7:0] REG_ROUTING = 8'h31;
  localparam logic [7:0] REG_PIN_DRIVE = 8'h33;
  localparam logic [7:0] RESET_CMD = 8'h40;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONES8 = 8'hff;
  // ==========================================
  // field positions
  localparam int BIT_TILT = 0;
  localparam int BIT_FLIP = 1;
  localparam int BIT_ANY_MOTION = 2;
  localparam int BIT_SHAKE = 3;
  localparam int BIT_TILT35 = 4;
  localparam int BIT_FIFO = 5;
  localparam int BIT_ACQ = 7;
  localparam int FEAT_TILTFLIP = 0;
  localparam int FEAT_ANY_MOTION = 2;
  localparam int FEAT_SHAKE = 3;
  localparam int FEAT_TILT35 = 4;
  localparam int FIFO_EN_BIT = 5;
  localparam int ROUTE_SWAP = 0;
  localparam int ROUTE_MERGE = 1;
  localparam int ROUTE_MERGE_PIN = 4;
  localparam int ROUTE_PER_BIT = 6;
  localparam int DRV_PIN1_PP = 0;
  localparam int DRV_PIN1_AH = 1;
  localparam int DRV_PIN2_PP = 2;
  localparam int DRV_PIN2_AH = 3;
  localparam int STAT_SAMPLE_FLAG = 7;
  localparam int MOTION_SRC_N = 5;
  localparam int FIFO_SRC_N = 3;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_MAX_NS = 10000;
  localparam int WAKE_CYC_INT = (WAKE_MAX_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WAKE_CYC = 8'(WAKE_CYC_INT);
  localparam logic [7:0] SAMPLE_CYC = WAKE_CYC;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    PH_SLEEP = 2'b00,
    PH_WAKE = 2'b01,
    PH_STANDBY = 2'b11
  } psic_phase_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } psic_req_t;
  typedef struct packed {
    logic out;
    logic oe;
  } psic_pin_t;
  typedef struct packed {
    logic [2:0] req_sync;
    logic [2:0] stop_sync;
    logic ack_tgl;
    logic [7:0] rdata;
    psic_phase_t phase;
    logic [1:0] mode_sel;
    logic waking;
    logic [7:0] wake_cnt;
    logic [7:0] samp_cnt;
    logic stop_seen;
    logic data_update;
    logic samp_flag;
    logic [7:0] int_en;
    logic [7:0] feat;
    logic [7:0] int_status;
    logic [7:0] fifo_ctl;
    logic [2:0] fifo_status;
    logic [7:0] route;
    logic [7:0] drive;
    psic_pin_t pin1;
    psic_pin_t pin2;
  } psic_core_t;
  typedef struct packed {
    psic_req_t req;
    logic req_tgl;
    logic stop_tgl;
    logic busy;
    logic [2:0] ack_sync;
    logic [7:0] rdata;
    logic rvalid;
  } psic_link_t;
endpackage

/* verilog/psic_link_front.sv */
// link-clock front end holding one register request across the crossing
`timescale 1ns/10ps
module psic_link_front (
  input wire logic bus_clk,
  input wire logic bus_rst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_stop,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  output logic bus_busy,
  output psic_pkg::psic_req_t link_req,
  output logic link_req_tgl,
  output logic link_stop_tgl,
  input wire logic core_ack_tgl,
  input wire logic [7:0] core_rdata
);
  import psic_pkg::*;

  psic_link_t st;
  psic_link_t next_st;

  // ==========================================
  // request hold and answer capture
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.ack_sync = {st.ack_sync[1:0], core_ack_tgl};
    if (bus_stop) begin
      next_st.stop_tgl = ~st.stop_tgl;
    end
    if (st.busy && (st.ack_sync[2] != st.ack_sync[1])) begin
      next_st.busy = 1'b0;
      next_st.rdata = core_rdata;
      next_st.rvalid = 1'b1;
    end else if (!st.busy && (bus_wr || bus_rd)) begin
      next_st.req.addr = bus_addr;
      next_st.req.wdata = bus_wdata;
      next_st.req.wr = bus_wr;
      next_st.req.rd = bus_rd & ~bus_wr;
      next_st.req_tgl = ~st.req_tgl;
      next_st.busy = 1'b1;
    end
  end

  always_ff @(posedge bus_clk) begin
    if (bus_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata = st.rdata;
  assign bus_rvalid = st.rvalid;
  assign bus_busy = st.busy;
  assign link_req = st.req;
  assign link_req_tgl = st.req_tgl;
  assign link_stop_tgl = st.stop_tgl;
endmodule

/* bench/psic_host_model.sv */
// host model driving the register bus of the sensor core
`timescale 1ns/10ps
module psic_host_model (
  input wire logic bus_clk,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  output logic bus_stop,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  input wire logic bus_busy
);
  int miss = 0;
  initial begin
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_stop = 1'b0;
  end
  // ==========================================
  // one request at a time, answer taken with rvalid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    int bad;
    n = 0;
    bad = 0;
    @(posedge bus_clk) #2;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = w;
    bus_rd = !w;
    // request stands until the answer strobe is seen
    do begin
      @(posedge bus_clk) #2;
      n++;
      if (bus_rvalid !== 1'b1 && bus_busy !== 1'b1) bad++;
    end while (bus_rvalid !== 1'b1 && n < 20);
    q = bus_rdata;
    if (bus_rvalid !== 1'b1) bad++;
    if (bus_busy !== 1'b0) bad++;
    if (bad != 0) begin
      miss += bad;
      $display("BAD %0t bus handshake", $time);
    end
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
  // ==========================================
  // stop condition between samples
  task automatic stop();
    @(posedge bus_clk) #2;
    bus_stop = 1'b1;
    @(posedge bus_clk) #2;
    bus_stop = 1'b0;
  endtask
endmodule

/* bench/tb.sv */
// self-checking bench of the power state and interrupt controller
`timescale 1ns/10ps
module tb;
  import psic_pkg::*;
  logic ref_clk = 1'b0;
  logic bus_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bus_rst = 1'b1;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, q;
  logic bus_wr, bus_rd, bus_stop, bus_rvalid, bus_busy, data_update;
  logic p1o, p1e, p2o, p2e;
  logic [4:0] motion_evt = 5'h00;
  logic [4:0] motion_raw = 5'h00;
  logic [2:0] fifo_evt = 3'h0;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int upd = 0;
  int seed = 32'h814f_0bdd;
  int rg [256];
  int ph, ist, fst, sfl;
  int regs [11] = '{'h03, 'h05, 'h06, 'h09, 'h13, 'h14, 'h2d, 'h2f, 'h31, 'h33, 'h20};
  int cfg [5] = '{'h06, 'h09, 'h2d, 'h31, 'h33};
  int rt [4] = '{'h00, 'h01, 'h02, 'h12};
  initial forever #25 ref_clk = ~ref_clk;
  initial begin
    #17;
    forever #62.5 bus_clk = ~bus_clk;
  end
  psic_power_irq_ctrl i_psic_power_irq_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(1'b1), .bus_clk(bus_clk), .bus_rst(bus_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_stop(bus_stop),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .bus_busy(bus_busy),
    .motion_evt(motion_evt), .motion_raw(motion_raw), .fifo_evt(fifo_evt),
    .irq_pin_one_out(p1o), .irq_pin_one_oe(p1e), .irq_pin_two_out(p2o),
    .irq_pin_two_oe(p2e), .data_update(data_update));
  psic_host_model host (.bus_clk(bus_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_stop(bus_stop), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .bus_busy(bus_busy));
  // ==========================================
  // compare tasks and reference model
  task automatic end_of_test();
    fail_count += host.miss;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    cyc++;
    if (data_update === 1'b1) upd++;
    if (cyc == 12000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input int exp);
    checked++;
    if (got !== 8'(exp)) begin
      fail_count++;
      $display("BAD %0t register got %h want %h", $time, got, 8'(exp));
    end
  endtask
  function automatic int pin(input int req, input int pp, input int ah);
    int l;
    l = ah ? req : !req;
    return pp ? l * 2 + 1 : !l;
  endfunction
  task automatic chkp();
    int r1, r2, r, d, a1, a2, e;
    r1 = ist != 0;
    r2 = fst != 0;
    r = rg['h31];
    d = rg['h33];
    a1 = r[1] ? (r[4] ? 0 : r1 | r2) : (r[0] ? r2 : r1);
    a2 = r[1] ? (r[4] ? r1 | r2 : 0) : (r[0] ? r1 : r2);
    e = pin(a1, d[0], d[1]) * 4 + pin(a2, d[2], d[3]);
    checked++;
    if ({p1o, p1e, p2o, p2e} !== 4'(e)) begin
      fail_count++;
      $display("BAD %0t pins got %b want %b", $time, {p1o, p1e, p2o, p2e}, 4'(e));
    end
  endtask
  task automatic bw(input int a, input int d);
    host.xfer(1'b1, 8'(a), 8'(d), q);
    if (ph == 1 && a != 'h07 && a != 'h14 && a != 'h1c) return;
    if (a == 'h07 && d != 2) begin
      if (ph == 1 && d != 1) sfl = 1;
      ph = d;
    end
    if (a == 'h14 && rg['h31][6]) begin
      ist &= ~d;
      if (d & 'h20) fst = 0;
    end else if (a == 'h14) begin
      ist = 0;
      fst = 0;
    end
    if (a == 'h1c && d == 'h40 && ph != 0) begin
      rg = '{default: 0};
      ph = 0;
      ist = 0;
      fst = 0;
    end
    if (a inside {'h06, 'h09, 'h2d, 'h31, 'h33}) rg[a] = d;
  endtask
  task automatic br(input int a, input int m);
    int e;
    host.xfer(1'b0, 8'(a), 8'h00, q);
    case (a)
      'h03, 'h13: e = motion_raw & {rg[9][4:2], rg[9][0], rg[9][0]};
      'h05: begin
        e = sfl * 128 + ph;
        sfl = 0;
      end
      'h14: e = ist | (fst ? 'h20 : 0);
      'h2f: e = fst;
      default: e = rg[a];
    endcase
    chk(q & 8'(m), e & m);
  endtask
  task automatic ev(input int m, input int f);
    int g;
    @(posedge ref_clk) #2;
    motion_evt = 5'(m);
    fifo_evt = 3'(f);
    @(posedge ref_clk) #2;
    motion_evt = 5'h00;
    fifo_evt = 3'h0;
    g = {rg[9][4] & rg[9][2], rg[9][3] & rg[9][2], rg[9][2], rg[9][0], rg[9][0]};
    if (ph == 1) ist |= m & g & rg[6];
    if (rg['h2d][5]) fst |= f & rg['h2d];
    @(posedge ref_clk) #2;
    chkp();
  endtask
  // ==========================================
  // main sequence
  initial begin
    rg = '{default: 0};
    ph = 0;
    ist = 0;
    fst = 0;
    sfl = 0;
    repeat (2) @(posedge ref_clk);
    #2 sys_rst = 1'b0;
    repeat (2) @(posedge bus_clk);
    #2 bus_rst = 1'b0;
    foreach (regs[i]) br(regs[i], 'hff);
    chkp();
    foreach (cfg[i]) begin
      bw(cfg[i], $random(seed) & 'h7f);
      br(cfg[i], 'hff);
    end
    chkp();
    bw('h1c, 'h40);
    br('h06, 'hff);
    bw('h07, 2);
    br('h05, 'hff);
    bw('h07, 3);
    br('h05, 'hff);
    bw('h1c, 'h40);
    #1000;
    foreach (regs[i]) br(regs[i], 'hff);
    bw('h07, 3);
    bw('h2d, 'h21);
    ev(0, 3);
    br('h2f, 'hff);
    br('h2f, 'hff);
    for (int i = 0; i < 16; i++) begin
      bw('h33, i);
      bw('h31, rt[i % 4]);
      chkp();
    end
    bw('h31, 'h00);
    bw('h33, 'h00);
    bw('h14, 'h5a);
    br('h14, 'hff);
    br('h2f, 'hff);
    chkp();
    bw('h06, 'h1b);
    bw('h09, 'h19);
    bw('h31, 'h40);
    bw('h07, 1);
    #10000;
    br('h05, 'h03);
    ev('h1f, 0);
    br('h14, 'hff);
    bw('h09, 'h1d);
    br('h09, 'hff);
    bw('h06, 'hff);
    br('h06, 'hff);
    bw('h14, 'h01);
    br('h14, 'hff);
    chkp();
    #12000;
    bw('h07, 3);
    br('h05, 'hff);
    br('h05, 'hff);
    bw('h09, 'h1d);
    motion_raw = 5'($random(seed));
    br('h03, 'hff);
    br('h13, 'hff);
    bw('h07, 1);
    #10000;
    upd = 0;
    ev('h1c, 0);
    br('h14, 'hff);
    bw('h14, 'h1a);
    br('h14, 'hff);
    chkp();
    #25000;
    br('h05, 'h03);
    chk(8'(upd), 0);
    host.stop();
    #12000;
    chk(8'(upd), 1);
    bw('h07, 0);
    br('h05, 'h03);
    bw('h06, 'h84);
    bw('h07, 1);
    #10000;
    ev('h04, 0);
    br('h14, 'hff);
    #11000;
    ist |= 'h80;
    br('h14, 'hff);
    end_of_test();
  end
endmodule
